//--- include/fsrc_pkg.sv
/*
 * fsrc_pkg: opcodes, status layout, descriptor fields and timing counts
 * for the flash suspend/resume pair.
 * assumes a single 100 MHz system clock shared by both ends.
 */
package fsrc_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_MHZ = 100;
   localparam int SUSP_LAT_US = 40;
   // longest time: round down
   localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;
   // actual device suspend time, well inside the ceiling
   localparam int SUSP_EXEC_CYC = SUSP_LAT_CYC / 2;
   localparam int RESUME_GAP_US = 128;
   // least time: round up
   localparam int RESUME_GAP_CYC = RESUME_GAP_US * CLK_MHZ;
   localparam int PGM_TIME_US = 320;
   localparam int PGM_TIME_CYC = PGM_TIME_US * CLK_MHZ;
   localparam int ERS_TIME_MS = 48;
   localparam int ERS_TIME_CYC = ERS_TIME_MS * 1000 * CLK_MHZ;
   localparam int WORK_W = 23;
   localparam int LAT_W = 12;
   localparam int GAP_W = 14;

   // ==========================================================
   // opcodes
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] OP_ERASE = 8'h20;
   localparam logic [7:0] OP_SFDP = 8'h5a;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] ARRAY_FILL = 8'hff;

   // ==========================================================
   // status byte layout
   localparam int ST_BUSY = 0;
   localparam int ST_ERS_SUSP = 2;
   localparam int ST_PGM_SUSP = 3;

   // ==========================================================
   // descriptor fields
   localparam logic [1:0] LAT_UNIT_128NS = 2'b00;
   localparam logic [1:0] LAT_UNIT_1US = 2'b01;
   localparam logic [1:0] LAT_UNIT_8US = 2'b10;
   localparam logic [1:0] LAT_UNIT_64US = 2'b11;
   localparam logic SUSP_SUPPORT_N = 1'b0;
   localparam logic [4:0] ERS_LAT_CNT = 5'b00100;
   localparam logic [3:0] ERS_GAP_CNT = 4'b0001;
   localparam logic [4:0] PGM_LAT_CNT = 5'b00100;
   localparam logic [3:0] PGM_GAP_CNT = 4'b0001;
   localparam logic DW12_RFU = 1'b1;
   localparam logic [3:0] PROHIBITED_OPS = 4'b1100;
   localparam logic [3:0] DW12_LOW = 4'b1100;
   localparam logic DPD_SUPPORT_N = 1'b0;
   localparam logic [31:0] DW14_REST = 32'h5cd5a2f7;
   localparam logic [7:0] SFDP_FIRST = 8'h2c;
   localparam logic [7:0] SFDP_LAST = 8'h37;

   localparam logic [31:0] SFDP_DW12 = {SUSP_SUPPORT_N, LAT_UNIT_8US, ERS_LAT_CNT,
      ERS_GAP_CNT, LAT_UNIT_8US, PGM_LAT_CNT, PGM_GAP_CNT, DW12_RFU, PROHIBITED_OPS,
      DW12_LOW};
   localparam logic [31:0] SFDP_DW13 = {OP_SUSPEND, OP_RESUME, OP_SUSPEND, OP_RESUME};
   localparam logic [31:0] SFDP_DW14 = {DPD_SUPPORT_N, DW14_REST[30:0]};

   // ==========================================================
   // host request kinds
   typedef enum logic [2:0] {
      FSRC_REQ_PROGRAM,
      FSRC_REQ_ERASE,
      FSRC_REQ_READ,
      FSRC_REQ_SUSPEND,
      FSRC_REQ_RESUME,
      FSRC_REQ_STATUS,
      FSRC_REQ_SFDP
   } fsrc_req_t;

endpackage

//--- include/fsrc_link_if.sv
/*
 * fsrc_link_if: framed byte link between host controller and flash.
 * assumes both ends sit on the same clock; no clocking here.
 */
`timescale 1ns/1ps
interface fsrc_link_if;
   logic frame;
   logic byte_valid;
   logic [7:0] byte_data;
   logic rsp_valid;
   logic [7:0] rsp_data;

   modport host (
      output frame,
      output byte_valid,
      output byte_data,
      input rsp_valid,
      input rsp_data
   );

   modport dev (
      input frame,
      input byte_valid,
      input byte_data,
      output rsp_valid,
      output rsp_data
   );
endinterface

//--- src/fsrc_device.sv
/*
 * fsrc_device: flash end of the suspend/resume link. decodes framed
 * commands, runs timed program and erase work, suspends and resumes it,
 * answers status and descriptor reads.
 * assumes the host keeps its own spacing and address restrictions.
 */
// Notes on behaviour
// - program and erase suspendable, support bit reads 0
// - erase suspends within 40 us, count 00100b
// - host waits 128 us before re-suspending erase
// - program suspends within 40 us, count 00100b
// - host waits 128 us before re-suspending program
// - no new erase while erase suspended
// - host starts no program during erase suspend
// - host avoids reading the erase-suspended sector
// - prohibited operations field reads 1100b
// - opcode 75h suspends erase or program
// - opcode 7Ah resumes erase or program
// - latency units 8 us, encoded 10b
// - deep power down supported, bit 31 clear
// - status opcode 05h, bit 0 busy
`timescale 1ns/1ps
module fsrc_device
   import fsrc_pkg::*;
#(
   parameter int PGM_CYC = PGM_TIME_CYC,
   parameter int ERS_CYC = ERS_TIME_CYC
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // link
   fsrc_link_if.dev lnk,
   // user side
   output logic BUSY,
   output logic ERASE_SUSPENDED,
   output logic PROGRAM_SUSPENDED,
   output logic OP_DONE,
   output logic [7:0] ACTIVE_SECTOR
);

   // ==========================================================
   // types and state
   typedef enum {
      D_READY,
      D_PROGRAM,
      D_ERASE,
      D_SUSPENDING,
      D_PGM_SUSP,
      D_ERS_SUSP
   } fsrc_dstate_t;

   fsrc_dstate_t state_reg, state_next;
   logic is_erase_reg, is_erase_next;
   logic [WORK_W-1:0] work_cnt_reg, work_cnt_next;
   logic [LAT_W-1:0] lat_cnt_reg, lat_cnt_next;
   logic [7:0] sector_reg, sector_next;
   logic done_reg, done_next;

   logic [1:0] byte_idx_reg, byte_idx_next;
   logic [7:0] op_reg, op_next;
   logic [7:0] arg_reg, arg_next;
   logic frame_d_reg, frame_d_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic [7:0] rsp_data_reg, rsp_data_next;

   logic busy;
   logic [7:0] status_byte;
   logic execute;

   // ==========================================================
   // descriptor lookup
   function automatic logic [7:0] sfdp_byte(input logic [7:0] addr);
      logic [3:0] ofs;
      logic [95:0] table_bits;
      ofs = 4'(addr - SFDP_FIRST);
      table_bits = {SFDP_DW14, SFDP_DW13, SFDP_DW12};
      if (addr < SFDP_FIRST || addr > SFDP_LAST) begin
         sfdp_byte = ARRAY_FILL;
      end else begin
         sfdp_byte = table_bits[ofs*8 +: 8];
      end
   endfunction

   // ==========================================================
   // status
   // busy stays high through the suspend latency, drops once parked
   assign busy = (state_reg == D_PROGRAM) || (state_reg == D_ERASE) ||
      (state_reg == D_SUSPENDING);
   always_comb begin
      status_byte = 8'h00;
      status_byte[ST_BUSY] = busy;
      status_byte[ST_ERS_SUSP] = (state_reg == D_ERS_SUSP);
      status_byte[ST_PGM_SUSP] = (state_reg == D_PGM_SUSP);
   end

   // commands take effect when the frame closes, like a real part
   assign execute = frame_d_reg && !lnk.frame && (byte_idx_reg != 2'd0);

   // ==========================================================
   // link decode
   always_comb begin
      byte_idx_next = byte_idx_reg;
      op_next = op_reg;
      arg_next = arg_reg;
      frame_d_next = lnk.frame;
      rsp_valid_next = 1'b0;
      rsp_data_next = rsp_data_reg;
      if (!lnk.frame) begin
         byte_idx_next = 2'd0;
      end else if (lnk.byte_valid) begin
         if (byte_idx_reg != 2'd3) begin
            byte_idx_next = byte_idx_reg + 2'd1;
         end
         if (byte_idx_reg == 2'd0) begin
            op_next = lnk.byte_data;
            if (lnk.byte_data == OP_STATUS) begin
               rsp_valid_next = 1'b1;
               rsp_data_next = status_byte;
            end
         end else if (byte_idx_reg == 2'd1) begin
            arg_next = lnk.byte_data;
            if (op_reg == OP_SFDP) begin
               rsp_valid_next = 1'b1;
               rsp_data_next = sfdp_byte(lnk.byte_data);
            end else if (op_reg == OP_READ) begin
               // array is outside this block; a fixed fill stands in
               rsp_valid_next = 1'b1;
               rsp_data_next = ARRAY_FILL;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         byte_idx_reg <= 2'd0;
         op_reg <= 8'h00;
         arg_reg <= 8'h00;
         frame_d_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 8'h00;
      end else begin
         byte_idx_reg <= byte_idx_next;
         op_reg <= op_next;
         arg_reg <= arg_next;
         frame_d_reg <= frame_d_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_data_reg <= rsp_data_next;
      end
   end

   // ==========================================================
   // operation sequencer
   always_comb begin
      state_next = state_reg;
      is_erase_next = is_erase_reg;
      work_cnt_next = work_cnt_reg;
      lat_cnt_next = lat_cnt_reg;
      sector_next = sector_reg;
      done_next = 1'b0;
      unique case (state_reg)
         D_READY: begin
            if (execute && byte_idx_reg >= 2'd2) begin
               if (op_reg == OP_PROGRAM) begin
                  state_next = D_PROGRAM;
                  is_erase_next = 1'b0;
                  work_cnt_next = WORK_W'(PGM_CYC);
                  sector_next = arg_reg;
               end else if (op_reg == OP_ERASE) begin
                  state_next = D_ERASE;
                  is_erase_next = 1'b1;
                  work_cnt_next = WORK_W'(ERS_CYC);
                  sector_next = arg_reg;
               end
            end
         end
         D_PROGRAM, D_ERASE: begin
            work_cnt_next = work_cnt_reg - WORK_W'(1);
            if (work_cnt_reg == WORK_W'(1)) begin
               state_next = D_READY;
               done_next = 1'b1;
            end else if (execute && op_reg == OP_SUSPEND) begin
               // one opcode parks either kind of work
               state_next = D_SUSPENDING;
               lat_cnt_next = LAT_W'(SUSP_EXEC_CYC);
            end
         end
         D_SUSPENDING: begin
            // work runs on until the safe stop point
            work_cnt_next = work_cnt_reg - WORK_W'(1);
            lat_cnt_next = lat_cnt_reg - LAT_W'(1);
            if (work_cnt_reg == WORK_W'(1)) begin
               state_next = D_READY;
               done_next = 1'b1;
            end else if (lat_cnt_reg == LAT_W'(1)) begin
               state_next = is_erase_reg ? D_ERS_SUSP : D_PGM_SUSP;
            end
         end
         D_PGM_SUSP: begin
            if (execute && op_reg == OP_RESUME) begin
               state_next = D_PROGRAM;
            end
         end
         D_ERS_SUSP: begin
            // new erase or program here is dropped: no nesting
            if (execute && op_reg == OP_RESUME) begin
               state_next = D_ERASE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state_reg <= D_READY;
         is_erase_reg <= 1'b0;
         work_cnt_reg <= '0;
         lat_cnt_reg <= '0;
         sector_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         is_erase_reg <= is_erase_next;
         work_cnt_reg <= work_cnt_next;
         lat_cnt_reg <= lat_cnt_next;
         sector_reg <= sector_next;
         done_reg <= done_next;
      end
   end

   // ==========================================================
   // outputs
   assign lnk.rsp_valid = rsp_valid_reg;
   assign lnk.rsp_data = rsp_data_reg;
   assign BUSY = busy;
   assign ERASE_SUSPENDED = (state_reg == D_ERS_SUSP);
   assign PROGRAM_SUSPENDED = (state_reg == D_PGM_SUSP);
   assign OP_DONE = done_reg;
   assign ACTIVE_SECTOR = sector_reg;

endmodule

//--- src/fsrc_host.sv
/*
 * fsrc_host: controller end. turns user requests into framed commands
 * and refuses requests that break suspend spacing or erase-suspend limits.
 * assumes one outstanding request at a time on the user port.
 */
`timescale 1ns/1ps
module fsrc_host
   import fsrc_pkg::*;
#(
   parameter int GAP_CYC = RESUME_GAP_CYC
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // link
   fsrc_link_if.host lnk,
   // request port
   input wire logic REQ_VALID,
   input wire fsrc_req_t REQ_OP,
   input wire logic [7:0] REQ_ARG,
   output logic REQ_READY,
   output logic REQ_REFUSED,
   // answer port
   output logic RSP_VALID,
   output logic [7:0] RSP_DATA,
   output logic DONE
);

   // ==========================================================
   // state
   typedef enum {
      H_IDLE,
      H_OPC,
      H_ARG,
      H_WAIT,
      H_END
   } fsrc_hstate_t;

   fsrc_hstate_t state_reg, state_next;
   logic frame_reg, frame_next;
   logic bvalid_reg, bvalid_next;
   logic [7:0] bdata_reg, bdata_next;
   logic [7:0] arg_reg, arg_next;
   logic need_arg_reg, need_arg_next;
   logic need_rsp_reg, need_rsp_next;
   logic refused_reg, refused_next;
   logic rvalid_reg, rvalid_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [GAP_W-1:0] gap_reg, gap_next;
   logic last_erase_reg, last_erase_next;
   logic ers_susp_reg, ers_susp_next;
   logic [7:0] susp_sector_reg, susp_sector_next;
   logic [7:0] cur_sector_reg, cur_sector_next;
   logic refuse;

   function automatic logic [7:0] req_opcode(input fsrc_req_t r);
      unique case (r)
         FSRC_REQ_PROGRAM: req_opcode = OP_PROGRAM;
         FSRC_REQ_ERASE: req_opcode = OP_ERASE;
         FSRC_REQ_READ: req_opcode = OP_READ;
         FSRC_REQ_SUSPEND: req_opcode = OP_SUSPEND;
         FSRC_REQ_RESUME: req_opcode = OP_RESUME;
         FSRC_REQ_STATUS: req_opcode = OP_STATUS;
         default: req_opcode = OP_SFDP;
      endcase
   endfunction

   // ==========================================================
   // refusal
   always_comb begin
      refuse = 1'b0;
      if (REQ_OP == FSRC_REQ_SUSPEND && gap_reg != '0) begin
         refuse = 1'b1;
      end
      if (ers_susp_reg && (REQ_OP == FSRC_REQ_ERASE)) begin
         refuse = 1'b1;
      end
      if (ers_susp_reg && (REQ_OP == FSRC_REQ_PROGRAM)) begin
         refuse = 1'b1;
      end
      if (ers_susp_reg && REQ_OP == FSRC_REQ_READ && REQ_ARG == susp_sector_reg) begin
         refuse = 1'b1;
      end
   end

   // ==========================================================
   // sequencer
   always_comb begin
      state_next = state_reg;
      frame_next = frame_reg;
      bvalid_next = 1'b0;
      bdata_next = bdata_reg;
      arg_next = arg_reg;
      need_arg_next = need_arg_reg;
      need_rsp_next = need_rsp_reg;
      refused_next = 1'b0;
      rvalid_next = 1'b0;
      rdata_next = rdata_reg;
      gap_next = (gap_reg != '0) ? gap_reg - GAP_W'(1) : gap_reg;
      last_erase_next = last_erase_reg;
      ers_susp_next = ers_susp_reg;
      susp_sector_next = susp_sector_reg;
      cur_sector_next = cur_sector_reg;
      unique case (state_reg)
         H_IDLE: begin
            if (REQ_VALID && refuse) begin
               refused_next = 1'b1;
            end else if (REQ_VALID) begin
               state_next = H_OPC;
               frame_next = 1'b1;
               bvalid_next = 1'b1;
               bdata_next = req_opcode(REQ_OP);
               arg_next = REQ_ARG;
               need_arg_next = (REQ_OP == FSRC_REQ_PROGRAM) || (REQ_OP == FSRC_REQ_ERASE) ||
                  (REQ_OP == FSRC_REQ_READ) || (REQ_OP == FSRC_REQ_SFDP);
               need_rsp_next = (REQ_OP == FSRC_REQ_STATUS) || (REQ_OP == FSRC_REQ_READ) ||
                  (REQ_OP == FSRC_REQ_SFDP);
               if (REQ_OP == FSRC_REQ_PROGRAM || REQ_OP == FSRC_REQ_ERASE) begin
                  last_erase_next = (REQ_OP == FSRC_REQ_ERASE);
                  cur_sector_next = REQ_ARG;
               end
               if (REQ_OP == FSRC_REQ_SUSPEND && last_erase_reg) begin
                  ers_susp_next = 1'b1;
                  susp_sector_next = cur_sector_reg;
               end
               if (REQ_OP == FSRC_REQ_RESUME) begin
                  // spacing lets the resumed work make headway
                  ers_susp_next = 1'b0;
                  gap_next = GAP_W'(GAP_CYC);
               end
            end
         end
         H_OPC: begin
            if (need_arg_reg) begin
               state_next = H_ARG;
               bvalid_next = 1'b1;
               bdata_next = arg_reg;
            end else if (need_rsp_reg) begin
               state_next = H_WAIT;
            end else begin
               state_next = H_END;
               frame_next = 1'b0;
            end
         end
         H_ARG: begin
            if (need_rsp_reg) begin
               state_next = H_WAIT;
            end else begin
               state_next = H_END;
               frame_next = 1'b0;
            end
         end
         H_WAIT: begin
            // the flash answers exactly one cycle after the byte
            rvalid_next = lnk.rsp_valid;
            rdata_next = lnk.rsp_data;
            state_next = H_END;
            frame_next = 1'b0;
         end
         H_END: begin
            state_next = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state_reg <= H_IDLE;
         frame_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bdata_reg <= 8'h00;
         arg_reg <= 8'h00;
         need_arg_reg <= 1'b0;
         need_rsp_reg <= 1'b0;
         refused_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 8'h00;
         gap_reg <= '0;
         last_erase_reg <= 1'b0;
         ers_susp_reg <= 1'b0;
         susp_sector_reg <= 8'h00;
         cur_sector_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         frame_reg <= frame_next;
         bvalid_reg <= bvalid_next;
         bdata_reg <= bdata_next;
         arg_reg <= arg_next;
         need_arg_reg <= need_arg_next;
         need_rsp_reg <= need_rsp_next;
         refused_reg <= refused_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         gap_reg <= gap_next;
         last_erase_reg <= last_erase_next;
         ers_susp_reg <= ers_susp_next;
         susp_sector_reg <= susp_sector_next;
         cur_sector_reg <= cur_sector_next;
      end
   end

   // ==========================================================
   // outputs
   assign lnk.frame = frame_reg;
   assign lnk.byte_valid = bvalid_reg;
   assign lnk.byte_data = bdata_reg;
   assign REQ_READY = (state_reg == H_IDLE);
   assign REQ_REFUSED = refused_reg;
   assign RSP_VALID = rvalid_reg;
   assign RSP_DATA = rdata_reg;
   assign DONE = (state_reg == H_END);

endmodule

//--- dv/fsrc_assertions.sv
/*
 * fsrc_assertions: link checker for the suspend/resume pair.
 * assumes plain link signals from the testbench top, one clock, sync reset.
 */
`timescale 1ns/1ps
module fsrc_assertions
   import fsrc_pkg::*;
#(
   parameter int GAP_CYC = RESUME_GAP_CYC
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // link
   input wire logic frame,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   // ==========================
   // frame tracking
   logic [1:0] idx_reg, idx_next;
   logic [7:0] op_reg, op_next, last_reg, last_next, sec_reg, sec_next;
   logic susp_reg, susp_next;
   logic [15:0] gap_reg, gap_next;
   logic first, arg;

   assign first = frame && byte_valid && idx_reg == 2'h0;
   assign arg = frame && byte_valid && idx_reg == 2'h1;

   // literal table kept apart from the package on purpose
   function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
      logic [95:0] t;
      t = 96'h5cd5a2f7_757a757a_441883cc;
      if (a >= 8'h2c && a <= 8'h37) begin
         return t[8*(a-8'h2c) +: 8];
      end
      return 8'hff;
   endfunction

   always_comb begin
      idx_next = idx_reg;
      op_next = op_reg;
      last_next = last_reg;
      sec_next = sec_reg;
      susp_next = susp_reg;
      gap_next = (gap_reg == 16'hffff) ? gap_reg : gap_reg + 16'h0001;
      if (!frame) begin
         idx_next = 2'h0;
      end else if (byte_valid && idx_reg != 2'h2) begin
         idx_next = idx_reg + 2'h1;
      end
      if (first) begin
         op_next = byte_data;
      end
      if (first && (byte_data == OP_ERASE || byte_data == OP_PROGRAM)) begin
         last_next = byte_data;
      end
      if (arg && op_reg == OP_ERASE) begin
         sec_next = byte_data;
      end
      if (first && byte_data == OP_SUSPEND && last_reg == OP_ERASE) begin
         susp_next = 1'b1;
      end
      if (first && byte_data == OP_RESUME) begin
         susp_next = 1'b0;
         gap_next = 16'h0000;
      end
   end

   // saturated gap count so a suspend right after reset is never flagged
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         idx_reg <= 2'h0;
         op_reg <= 8'h00;
         last_reg <= 8'h00;
         sec_reg <= 8'h00;
         susp_reg <= 1'b0;
         gap_reg <= 16'hffff;
      end else begin
         idx_reg <= idx_next;
         op_reg <= op_next;
         last_reg <= last_next;
         sec_reg <= sec_next;
         susp_reg <= susp_next;
         gap_reg <= gap_next;
      end
   end

   // ==========================
   // properties
   a_status_answer: assert property (
      first && byte_data == OP_STATUS |=> rsp_valid && rsp_data[7:4] == 4'h0 && !rsp_data[1])
      else $error("status answer missing or malformed");
   a_sfdp_answer: assert property (
      arg && op_reg == OP_SFDP |=> rsp_valid && rsp_data == sfdp_byte($past(byte_data)))
      else $error("descriptor byte wrong");
   a_rsp_cause: assert property (
      rsp_valid |-> $past(frame) && $past(byte_valid))
      else $error("answer without a byte before it");
   a_suspend_single: assert property (
      first && byte_data == OP_SUSPEND |=> !frame ##1 !frame)
      else $error("suspend frame not one byte");
   a_resume_single: assert property (
      first && byte_data == OP_RESUME |=> !byte_valid [*2])
      else $error("resume frame not one byte");
   a_resume_gap: assert property (
      first && byte_data == OP_SUSPEND |-> gap_reg >= 16'(GAP_CYC - 2))
      else $error("suspend too soon after resume");
   a_no_nested_work: assert property (
      susp_reg && first |-> byte_data != OP_ERASE && byte_data != OP_PROGRAM)
      else $error("work started during erase park");
   a_read_elsewhere: assert property (
      susp_reg && arg && op_reg == OP_READ |-> byte_data != sec_reg)
      else $error("read of parked sector");
endmodule

//--- dv/fsrc_tb_top.sv
/*
 * fsrc_tb_top: both ends joined by one link; user side driven by tasks.
 * assumes short work counts so the suspend latency of 2000 cycles lands.
 */
`timescale 1ns/1ps
module fsrc_tb_top
   import fsrc_pkg::*;
;
   localparam int GAP = 20;
   localparam int LAT = SUSP_LAT_CYC;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   fsrc_req_t req_op = FSRC_REQ_STATUS;
   logic [7:0] req_arg = 8'h00;
   logic req_ready, req_refused, rsp_valid, done, busy, ers_susp, pgm_susp, op_done;
   logic [7:0] rsp_data, act_sector, dat;
   logic refd;
   int errors = 0;
   int check_count = 0;
   int n;
   logic [95:0] sfdp_exp = 96'h5cd5a2f7_757a757a_441883cc;

   fsrc_link_if lnk_if();
   always #5 clk_sys = ~clk_sys;

   // ==========================
   // both ends and checker
   fsrc_host #(.GAP_CYC(GAP)) u_fsrc_host (.CLK_SYS(clk_sys), .RST_N(rst_n), .lnk(lnk_if),
      .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_ARG(req_arg), .REQ_READY(req_ready),
      .REQ_REFUSED(req_refused), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .DONE(done));
   fsrc_device #(.PGM_CYC(3000), .ERS_CYC(10000)) u_fsrc_device (.CLK_SYS(clk_sys),
      .RST_N(rst_n), .lnk(lnk_if), .BUSY(busy), .ERASE_SUSPENDED(ers_susp),
      .PROGRAM_SUSPENDED(pgm_susp), .OP_DONE(op_done), .ACTIVE_SECTOR(act_sector));
   fsrc_assertions #(.GAP_CYC(GAP)) u_fsrc_assertions (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .frame(lnk_if.frame), .byte_valid(lnk_if.byte_valid), .byte_data(lnk_if.byte_data),
      .rsp_valid(lnk_if.rsp_valid), .rsp_data(lnk_if.rsp_data));

   // ==========================
   // tasks
   task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_f(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one request, held until taken, then followed to its end
   task automatic req(input fsrc_req_t op, input logic [7:0] arg);
      int k;
      refd = 1'b0;
      dat = 8'hxx;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op <= op;
      req_arg <= arg;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (req_ready !== 1'b1 && k < 50);
      req_valid <= 1'b0;
      k = 0;
      while (done !== 1'b1 && refd !== 1'b1 && k < 50) begin
         @(posedge clk_sys);
         k++;
         if (req_refused === 1'b1) refd = 1'b1;
         if (rsp_valid === 1'b1) dat = rsp_data;
      end
      chk_f(k < 50, 1'b1);
   endtask

   // 0 idle, 1 erase parked, 2 program parked, 3 work done
   task automatic wait_for(input int which, input int limit);
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < limit) begin
         @(posedge clk_sys);
         n++;
         case (which)
            0: hit = (busy === 1'b0);
            1: hit = (ers_susp === 1'b1);
            2: hit = (pgm_susp === 1'b1);
            default: hit = (op_done === 1'b1);
         endcase
      end
      chk_f(hit, 1'b1);
   endtask

   task automatic end_of_test();
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================
   // tests
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         req(FSRC_REQ_SFDP, 8'h2c + i[7:0]);
         chk_b(dat, (i < 12) ? sfdp_exp[8*i +: 8] : 8'hff);
      end
      req(FSRC_REQ_STATUS, 8'h00);
      chk_b(dat, 8'h00);
      req(FSRC_REQ_PROGRAM, 8'h05);
      req(FSRC_REQ_STATUS, 8'h00);
      chk_b(dat, 8'h01);
      chk_f(busy, 1'b1);
      chk_b(act_sector, 8'h05);
      req(FSRC_REQ_SUSPEND, 8'h00);
      wait_for(2, LAT);
      req(FSRC_REQ_STATUS, 8'h00);
      chk_b(dat, 8'h08);
      req(FSRC_REQ_RESUME, 8'h00);
      req(FSRC_REQ_SUSPEND, 8'h00);
      chk_f(refd, 1'b1);
      req(FSRC_REQ_STATUS, 8'h00);
      chk_b(dat, 8'h01);
      wait_for(3, 4000);
      chk_f(busy, 1'b0);
      // erase parked: nested work and its own sector are off limits
      req(FSRC_REQ_ERASE, 8'h09);
      req(FSRC_REQ_SUSPEND, 8'h00);
      wait_for(1, LAT);
      chk_b(act_sector, 8'h09);
      req(FSRC_REQ_STATUS, 8'h00);
      chk_b(dat, 8'h04);
      req(FSRC_REQ_ERASE, 8'h0a);
      chk_f(refd, 1'b1);
      req(FSRC_REQ_PROGRAM, 8'h0a);
      chk_f(refd, 1'b1);
      req(FSRC_REQ_READ, 8'h09);
      chk_f(refd, 1'b1);
      req(FSRC_REQ_READ, 8'h03);
      chk_b(dat, 8'hff);
      req(FSRC_REQ_STATUS, 8'h00);
      chk_b(dat, 8'h04);
      req(FSRC_REQ_RESUME, 8'h00);
      req(FSRC_REQ_SUSPEND, 8'h00);
      chk_f(refd, 1'b1);
      repeat (GAP) @(posedge clk_sys);
      req(FSRC_REQ_SUSPEND, 8'h00);
      chk_f(refd, 1'b0);
      wait_for(1, LAT);
      req(FSRC_REQ_RESUME, 8'h00);
      wait_for(3, 12000);
      req(FSRC_REQ_STATUS, 8'h00);
      chk_b(dat, 8'h00);
      end_of_test();
   end

   // hang guard, over four times the expected run
   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      end_of_test();
   end
endmodule
